// >>> ocas_adder_shifter.v
// Purpose: 16-bit ones-complement adder/shifter with overflow flag.
// Assumes: Sequencer inputs are on mclk; APB3 slave, no wait states.
// Notes:   Operand registers live here and are loaded by software.
//
// Overview of operation
// RULE_01: Selected second-operand register is gated onto the second operand port.
// RULE_02: With no second-operand select, every second operand bit is one.
// RULE_03: Increment select presents plus one on the first operand port.
// RULE_04: Adder is eight two-bit groups; bit 15 and bit 0 are adjacent.
// RULE_05: Sum formed by subtracting the negated second operand from the first.
// RULE_06: Zero minus one generates a borrow; one minus zero absorbs it.
// RULE_07: Equal subtracted bits form an enable that passes and toggles a borrow.
// RULE_08: Group 0 borrow in is upper section borrow or lower borrow with enable.
// RULE_09: Wraparound borrow from stage 15 borrow or enable with group borrow.
// RULE_10: Positive overflow is wraparound borrow with result bit 15 one.
// RULE_11: Negative overflow is result bit 15 zero with stage 15 satisfied.
// RULE_12: Add sets overflow flag at strobe c of the second operand cycle.
// RULE_13: Register ops selecting xor or logical product never set overflow.
// RULE_14: Divide sets overflow flag when A ends negative at completion.
// RULE_15: Return from trap loads overflow flag from fetched word bit 15.
// RULE_16: Trap entry injects the overflow flag into second operand bit 15.
// RULE_17: Sense-overflow skip clears the flag at strobe c of first cycle.
// RULE_18: Left shifts rotate bit 15 into bit 0.
// RULE_19: Right shifts drop bit 0 and replicate bit 15 into bit 14.
// RULE_20: Long shift flip-flop set at strobe b for QA shifts, multiply, divide.
// RULE_21: Long left first routes A15 to Q0 and catches Q15 in the bucket.
// RULE_22: Long left second shifts the bucket into A bit 0.
// RULE_23: Divide step without wraparound borrow sets the bucket at strobe a.
// RULE_24: Long right catches Q0 in the bucket, then places it in A bit 15.
// RULE_25: Overflow flag holds except under its defined set and clear events.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "ocas_defs.vh"

module ocas_adder_shifter #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Sequencer phase strobes and cycle qualifiers
  input wire strobeA,
  input wire strobeB,
  input wire strobeC,
  input wire firstCycle,
  input wire secondCycle,
  input wire operandPhase,
  // Instruction context
  input wire addOp,
  input wire regToRegOp,
  input wire instrBit6,
  input wire instrBit7,
  input wire multiplyOp,
  input wire divideOp,
  input wire divideStep,
  input wire divideDone,
  input wire returnFromTrap,
  input wire trapEntry,
  input wire senseOverflow,
  input wire memWord15,
  input wire shiftBit5,
  input wire shiftBit6,
  input wire longShiftDone,
  // Results
  output reg [WIDTH-1:0] resultOut,
  output reg overflowFlag,
  output reg bitBucket,
  output reg longShift
);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  reg [`OCAS_CTRL_WIDTH-1:0] ctrl_q;
  reg [WIDTH-1:0] regA_q;
  reg [WIDTH-1:0] regQ_q;
  reg [WIDTH-1:0] regX_q;
  reg [WIDTH-1:0] regY_q;
  reg [WIDTH-1:0] regP_q;
  reg [WIDTH-1:0] regMask_q;

  wire [3:0] firstSel;
  wire [3:0] secondSel;
  wire [1:0] funcSel;
  wire [1:0] shiftSel;
  assign firstSel = ctrl_q[`OCAS_CTRL_FSEL_LSB +: 4];
  assign secondSel = ctrl_q[`OCAS_CTRL_SSEL_LSB +: 4];
  assign funcSel = ctrl_q[`OCAS_CTRL_FUNC_LSB +: 2];
  assign shiftSel = ctrl_q[`OCAS_CTRL_SHIFT_LSB +: 2];

  // ----------------------------------------------------------------
  // Operand fan-in
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] firstOperand;
  reg [WIDTH-1:0] secondOperand;

  always @*
  begin
    // Unselected port floats to all ones, like the open gate inputs
    if (firstSel == 4'h0)
    begin
      firstOperand = {WIDTH{1'b1}};
    end
    else
    begin
      firstOperand = ({WIDTH{firstSel[`OCAS_FSEL_X]}} & regX_q)
        | ({WIDTH{firstSel[`OCAS_FSEL_Y]}} & regY_q)
        | ({WIDTH{firstSel[`OCAS_FSEL_A]}} & regA_q)
        | {{(WIDTH-1){1'b0}}, firstSel[`OCAS_FSEL_INC]}; // see RULE_03
    end
  end

  always @*
  begin
    if (secondSel == 4'h0)
    begin
      secondOperand = {WIDTH{1'b1}}; // see RULE_02
    end
    else
    begin
      // Gates wire-or; software keeps to one select at a time
      secondOperand = ({WIDTH{secondSel[`OCAS_SSEL_Q]}} & regQ_q)
        | ({WIDTH{secondSel[`OCAS_SSEL_X]}} & regX_q)
        | ({WIDTH{secondSel[`OCAS_SSEL_P]}} & regP_q)
        | ({WIDTH{secondSel[`OCAS_SSEL_MASK]}} & regMask_q); // see RULE_01
    end
    if (trapEntry)
    begin
      secondOperand[WIDTH-1] = overflowFlag; // see RULE_16
    end
  end

  // ----------------------------------------------------------------
  // Stage conditions
  // ----------------------------------------------------------------
  // The second operand is complemented before subtraction, so an
  // enable is unlike bits, a borrow both zero, a satisfy both one.
  wire [WIDTH-1:0] stageGen;
  wire [WIDTH-1:0] stageEnb;
  wire [WIDTH-1:0] stageSat;
  wire [WIDTH-1:0] stageDif;
  assign stageGen = ~firstOperand & ~secondOperand; // see RULE_06
  assign stageEnb = firstOperand ^ secondOperand; // see RULE_07
  assign stageSat = firstOperand & secondOperand; // see RULE_06
  assign stageDif = firstOperand ^ ~secondOperand; // see RULE_05

  // ----------------------------------------------------------------
  // Group look-ahead: group k holds stages 2k-1 and 2k
  // ----------------------------------------------------------------
  wire [7:0] grpBorrow;
  wire [7:0] grpEnable;
  assign grpBorrow[0] = 1'b0;
  assign grpEnable[0] = 1'b0;

  genvar gk;
  generate
    for (gk = 1; gk < 8; gk = gk + 1)
    begin : g_group
      assign grpBorrow[gk] = stageGen[2*gk]
        | (stageEnb[2*gk] & stageGen[2*gk-1]); // see RULE_04
      assign grpEnable[gk] = stageEnb[2*gk] & stageEnb[2*gk-1];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sections, end-around borrow and stage borrows
  // ----------------------------------------------------------------
  reg secBorrowLo;
  reg secBorrowHi;
  reg secEnableHi;
  reg grp0BorrowIn;
  reg wraparoundBorrow;
  reg stage0Out;
  reg [WIDTH-1:0] stageBorrowIn;
  integer si;

  always @*
  begin
    secBorrowLo = stageGen[0];
    secBorrowHi = 1'b0;
    secEnableHi = 1'b1;
    for (si = 1; si < 4; si = si + 1)
    begin
      secBorrowLo = grpBorrow[si] | (grpEnable[si] & secBorrowLo);
    end
    for (si = 4; si < 8; si = si + 1)
    begin
      secBorrowHi = grpBorrow[si] | (grpEnable[si] & secBorrowHi);
      secEnableHi = secEnableHi & grpEnable[si];
    end
    grp0BorrowIn = secBorrowHi | (secBorrowLo & secEnableHi); // see RULE_08
    wraparoundBorrow = stageGen[WIDTH-1]
      | (stageEnb[WIDTH-1] & grp0BorrowIn); // see RULE_09
    // Wraparound acts as stage 0's borrow; its result seeds stage 1
    stage0Out = stageGen[0] | (stageEnb[0] & wraparoundBorrow);
    stageBorrowIn[0] = wraparoundBorrow; // see RULE_04
    stageBorrowIn[1] = stage0Out;
    for (si = 2; si < WIDTH; si = si + 1)
    begin
      stageBorrowIn[si] = stageGen[si-1]
        | (stageEnb[si-1] & stageBorrowIn[si-1]); // see RULE_06
    end
  end

  // ----------------------------------------------------------------
  // Adder output and overflow detection
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] sum;

  always @*
  begin
    if (funcSel == `OCAS_FUNC_AND)
    begin
      sum = firstOperand & secondOperand;
    end
    else if (funcSel == `OCAS_FUNC_XOR)
    begin
      sum = stageEnb;
    end
    else
    begin
      sum = stageDif ^ stageBorrowIn; // see RULE_07
    end
  end

  wire isAdd;
  wire ovfPositive;
  wire ovfNegative;
  wire ovfDetect;
  assign isAdd = (funcSel == `OCAS_FUNC_ADD);
  assign ovfPositive = wraparoundBorrow & sum[WIDTH-1]; // see RULE_10
  assign ovfNegative = ~sum[WIDTH-1] & stageSat[WIDTH-1]; // see RULE_11
  assign ovfDetect = isAdd & (ovfPositive | ovfNegative);

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  wire shiftQA;
  wire longContext;
  wire longLeftFirst;
  wire longLeftSecond;
  wire longRightSecond;
  assign shiftQA = shiftBit5 & shiftBit6;
  assign longContext = shiftQA | multiplyOp | divideOp;
  assign longLeftFirst = longContext & ~longShift
    & (shiftSel == `OCAS_SHIFT_LEFT);
  assign longLeftSecond = longShift & (shiftSel == `OCAS_SHIFT_LEFT);
  assign longRightSecond = longShift & (shiftSel == `OCAS_SHIFT_RIGHT);

  reg leftFill;
  reg rightTop;
  reg [WIDTH-1:0] shifted;

  always @*
  begin
    if (longLeftFirst)
    begin
      leftFill = regA_q[WIDTH-1]; // see RULE_21
    end
    else if (longLeftSecond)
    begin
      leftFill = bitBucket; // see RULE_22
    end
    else
    begin
      leftFill = sum[WIDTH-1]; // see RULE_18
    end
    rightTop = longRightSecond ? bitBucket : sum[WIDTH-1]; // see RULE_24
    if (shiftSel == `OCAS_SHIFT_LEFT)
    begin
      shifted = {sum[WIDTH-2:0], leftFill}; // see RULE_18
    end
    else if (shiftSel == `OCAS_SHIFT_RIGHT)
    begin
      shifted = {rightTop, sum[WIDTH-1:1]}; // see RULE_19
    end
    else
    begin
      shifted = sum;
    end
  end

  // ----------------------------------------------------------------
  // Overflow flag, bucket and long-shift flip-flop
  // ----------------------------------------------------------------
  wire addSetsFlag;
  wire divSetsFlag;
  wire trapLoadsFlag;
  wire senseClears;
  // Logical register ops must not set the flag from stale borrows
  assign addSetsFlag = strobeC & secondCycle & operandPhase & ovfDetect
    & (addOp | (regToRegOp & ~instrBit6 & ~instrBit7)); // see RULE_12 RULE_13
  assign divSetsFlag = divideOp & divideDone & regA_q[WIDTH-1]; // see RULE_14
  assign trapLoadsFlag = strobeC & firstCycle & returnFromTrap;
  assign senseClears = strobeC & firstCycle & senseOverflow;

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      overflowFlag <= 1'b0;
    end
    else if (addSetsFlag | divSetsFlag)
    begin
      overflowFlag <= 1'b1; // set wins over a coincident clear
    end
    else if (trapLoadsFlag)
    begin
      overflowFlag <= memWord15; // see RULE_15
    end
    else if (senseClears)
    begin
      overflowFlag <= 1'b0; // see RULE_17
    end
  end // see RULE_25

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      bitBucket <= 1'b0;
    end
    else if (strobeA)
    begin
      if (divideStep)
      begin
        bitBucket <= ~wraparoundBorrow; // see RULE_23
      end
      else if (longLeftFirst)
      begin
        bitBucket <= sum[WIDTH-1]; // see RULE_21
      end
      else if (~longShift & (shiftSel == `OCAS_SHIFT_RIGHT)
        & (shiftQA | multiplyOp))
      begin
        bitBucket <= sum[0]; // see RULE_24
      end
    end
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      longShift <= 1'b0;
    end
    else if (strobeB & longContext)
    begin
      longShift <= 1'b1; // see RULE_20
    end
    else if (longShiftDone)
    begin
      longShift <= 1'b0;
    end
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      resultOut <= `OCAS_REG_RESET;
    end
    else
    begin
      resultOut <= shifted;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Read data is captured in the setup cycle so it leaves a flop and
  // the access phase still completes at once.
  function is_mapped;
    input [7:0] addr;
    begin
      is_mapped = (addr <= `OCAS_OFF_STATUS) && (addr[1:0] == 2'b00);
    end
  endfunction

  function is_writable;
    input [7:0] addr;
    begin
      is_writable = is_mapped(addr) && (addr < `OCAS_OFF_RESULT);
    end
  endfunction

  wire apbWrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable
    & (pwrite ? ~is_writable(paddr) : ~is_mapped(paddr));
  assign apbWrite = psel & penable & pwrite & is_writable(paddr);

  wire [31:0] statusWord;
  assign statusWord = {27'h0000000, ovfDetect, wraparoundBorrow,
    longShift, bitBucket, overflowFlag};

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q <= `OCAS_CTRL_RESET;
      regA_q <= `OCAS_REG_RESET;
      regQ_q <= `OCAS_REG_RESET;
      regX_q <= `OCAS_REG_RESET;
      regY_q <= `OCAS_REG_RESET;
      regP_q <= `OCAS_REG_RESET;
      regMask_q <= `OCAS_REG_RESET;
    end
    else if (apbWrite)
    begin
      if (paddr == `OCAS_OFF_CTRL)
        ctrl_q <= pwdata[`OCAS_CTRL_WIDTH-1:0];
      else if (paddr == `OCAS_OFF_REG_A)
        regA_q <= pwdata[WIDTH-1:0];
      else if (paddr == `OCAS_OFF_REG_Q)
        regQ_q <= pwdata[WIDTH-1:0];
      else if (paddr == `OCAS_OFF_REG_X)
        regX_q <= pwdata[WIDTH-1:0];
      else if (paddr == `OCAS_OFF_REG_Y)
        regY_q <= pwdata[WIDTH-1:0];
      else if (paddr == `OCAS_OFF_REG_P)
        regP_q <= pwdata[WIDTH-1:0];
      else if (paddr == `OCAS_OFF_REG_MASK)
        regMask_q <= pwdata[WIDTH-1:0];
    end
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata <= 32'h00000000;
    end
    else if (psel & ~penable)
    begin
      if (paddr == `OCAS_OFF_CTRL)
        prdata <= {{(32-`OCAS_CTRL_WIDTH){1'b0}}, ctrl_q};
      else if (paddr == `OCAS_OFF_REG_A)
        prdata <= {{(32-WIDTH){1'b0}}, regA_q};
      else if (paddr == `OCAS_OFF_REG_Q)
        prdata <= {{(32-WIDTH){1'b0}}, regQ_q};
      else if (paddr == `OCAS_OFF_REG_X)
        prdata <= {{(32-WIDTH){1'b0}}, regX_q};
      else if (paddr == `OCAS_OFF_REG_Y)
        prdata <= {{(32-WIDTH){1'b0}}, regY_q};
      else if (paddr == `OCAS_OFF_REG_P)
        prdata <= {{(32-WIDTH){1'b0}}, regP_q};
      else if (paddr == `OCAS_OFF_REG_MASK)
        prdata <= {{(32-WIDTH){1'b0}}, regMask_q};
      else if (paddr == `OCAS_OFF_RESULT)
        prdata <= {{(32-WIDTH){1'b0}}, resultOut};
      else if (paddr == `OCAS_OFF_STATUS)
        prdata <= statusWord;
      else
        prdata <= 32'h00000000;
    end
  end

endmodule

// >>> ocas_adder_shifter_bench.sv
// Purpose: Self-checking bench for the adder/shifter.
// Assumes: APB master with one idle cycle between transfers.
// Notes: Cycle qualifiers are packed in ctx, strobes come from the model.
`timescale 1ns/1ps
`include "ocas_defs.vh"
module ocas_adder_shifter_bench;
  localparam [17:0] FIRST = 18'h1, SECOND = 18'h2, OPER = 18'h4, ADD = 18'h8;
  localparam [17:0] RTR = 18'h10, B6 = 18'h20, B7 = 18'h40, MUL = 18'h80;
  localparam [17:0] DIV = 18'h100, DSTEP = 18'h200, DDONE = 18'h400, RFT = 18'h800;
  localparam [17:0] TRAP = 18'h1000, SENSE = 18'h2000, MEM15 = 18'h4000, SB5 = 18'h8000;
  localparam [17:0] SB6 = 18'h10000, LDONE = 18'h20000;
  reg mclk = 1'b0;
  reg resetn = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg fire = 1'b0;
  reg [1:0] kind = 2'h0;
  reg [3:0] lag = 4'h0;
  reg [17:0] ctx = 18'h0;
  reg [31:0] rd;
  reg er;
  localparam [79:0] FV = 80'hffff_0001_0010_0200_1234;
  localparam [79:0] SV = 80'hffff_0f00_00ff_1234_0101;
  integer errCount = 0;
  integer checkCount = 0;
  integer cycles = 0;
  integer i, j;
  wire [31:0] prdata;
  wire pready, pslverr, overflowFlag, bitBucket, longShift, strobeA, strobeB, strobeC, busy;
  wire [15:0] resultOut;
  always #5 mclk = ~mclk;
  ocas_adder_shifter i_ocas_adder_shifter (.mclk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .strobeA, .strobeB, .strobeC, .firstCycle(ctx[0]),
    .secondCycle(ctx[1]), .operandPhase(ctx[2]), .addOp(ctx[3]), .regToRegOp(ctx[4]),
    .instrBit6(ctx[5]), .instrBit7(ctx[6]), .multiplyOp(ctx[7]), .divideOp(ctx[8]),
    .divideStep(ctx[9]), .divideDone(ctx[10]), .returnFromTrap(ctx[11]), .trapEntry(ctx[12]),
    .senseOverflow(ctx[13]), .memWord15(ctx[14]), .shiftBit5(ctx[15]), .shiftBit6(ctx[16]),
    .longShiftDone(ctx[17]), .resultOut, .overflowFlag, .bitBucket, .longShift);
  ocas_seq_model i_ocas_seq_model (.mclk, .resetn, .fire, .kind, .lag, .strobeA, .strobeB,
    .strobeC, .busy);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task reportAndStop;
    $display("checks %0d errors %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task checkWord(input [31:0] got, input [31:0] exp);
    checkCount = checkCount + 1;
    if (got !== exp)
    begin
      errCount = errCount + 1;
      $display("unexpected at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task checkBit(input got, input exp);
    checkCount = checkCount + 1;
    if (got !== exp)
    begin
      errCount = errCount + 1;
      $display("unexpected at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task ctl(input [3:0] f, input [3:0] s, input [1:0] sh);
    apb(1'b1, `OCAS_OFF_CTRL, {20'h0, sh, `OCAS_FUNC_ADD, s, f});
  endtask
  task expResult(input [15:0] e);
    repeat (2) @(posedge mclk);
    #1;
    checkWord({16'h0, resultOut}, {16'h0, e});
  endtask
  task setCtx(input [17:0] v);
    @(posedge mclk);
    ctx <= v;
  endtask
  task pulseCtx(input [17:0] keep, input [17:0] p);
    setCtx(keep | p);
    setCtx(keep);
    @(posedge mclk);
    #1;
  endtask
  task strobe(input [1:0] k, input [3:0] l);
    @(posedge mclk);
    fire <= 1'b1;
    kind <= k;
    lag <= l;
    @(posedge mclk);
    fire <= 1'b0;
    #1;
    wait (busy === 1'b0);
    @(posedge mclk);
    #1;
  endtask
  function [15:0] oadd(input [15:0] a, input [15:0] b);
    reg [16:0] s;
    s = a + b;
    oadd = s[15:0] + s[16];
  endfunction
  always @(posedge mclk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      errCount = errCount + 1;
      $display("unexpected at %0t: timeout", $time);
      reportAndStop;
    end
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    #1;
    checkBit(overflowFlag, 1'b0);
    checkBit(longShift, 1'b0);
    apb(1'b0, `OCAS_OFF_STATUS, 32'h0);
    checkWord(rd, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    checkBit(er, 1'b1);
    apb(1'b1, `OCAS_OFF_RESULT, 32'h1);
    checkBit(er, 1'b1);
    apb(1'b1, `OCAS_OFF_REG_A, 32'h0010);
    apb(1'b1, `OCAS_OFF_REG_Q, 32'h0101);
    apb(1'b1, `OCAS_OFF_REG_X, 32'h1234);
    apb(1'b1, `OCAS_OFF_REG_Y, 32'h0200);
    apb(1'b1, `OCAS_OFF_REG_P, 32'h00ff);
    apb(1'b1, `OCAS_OFF_REG_MASK, 32'h0f00);
    for (i = 0; i < 5; i = i + 1)
      for (j = 0; j < 5; j = j + 1)
      begin
        ctl((i < 4) ? (4'h1 << i) : 4'h0, (j < 4) ? (4'h1 << j) : 4'h0, `OCAS_SHIFT_NONE);
        expResult(oadd(FV[16*i +: 16], SV[16*j +: 16]));
      end
    apb(1'b0, `OCAS_OFF_RESULT, 32'h0);
    checkWord(rd, 32'h0000ffff);
    apb(1'b1, `OCAS_OFF_REG_X, 32'hfffe);
    apb(1'b1, `OCAS_OFF_REG_Q, 32'h0003);
    ctl(4'h1, 4'h1, `OCAS_SHIFT_NONE);
    expResult(16'h0002);
    apb(1'b1, `OCAS_OFF_REG_X, 32'h5554);
    apb(1'b1, `OCAS_OFF_REG_Q, 32'haaaa);
    expResult(16'hfffe);
    apb(1'b1, `OCAS_OFF_REG_X, 32'h4000);
    apb(1'b1, `OCAS_OFF_REG_Q, 32'h4000);
    expResult(16'h8000);
    setCtx(SECOND | OPER | RTR | B6);
    strobe(2'h2, 4'h0);
    checkBit(overflowFlag, 1'b0);
    setCtx(SECOND | OPER | RTR | B7);
    strobe(2'h2, 4'h1);
    checkBit(overflowFlag, 1'b0);
    setCtx(SECOND | OPER | ADD);
    strobe(2'h2, 4'h3);
    checkBit(overflowFlag, 1'b1);
    setCtx(18'h0);
    strobe(2'h2, 4'h0);
    checkBit(overflowFlag, 1'b1);
    apb(1'b1, `OCAS_OFF_CTRL, 32'h211);
    expResult(16'h4000);
    apb(1'b1, `OCAS_OFF_REG_P, 32'h0001);
    setCtx(TRAP);
    ctl(4'h8, 4'h4, `OCAS_SHIFT_NONE);
    expResult(16'h8002);
    setCtx(FIRST | SENSE);
    strobe(2'h2, 4'h0);
    checkBit(overflowFlag, 1'b0);
    setCtx(TRAP);
    expResult(16'h0002);
    setCtx(FIRST | RFT | MEM15);
    strobe(2'h2, 4'h2);
    checkBit(overflowFlag, 1'b1);
    setCtx(FIRST | RFT);
    strobe(2'h2, 4'h0);
    checkBit(overflowFlag, 1'b0);
    apb(1'b1, `OCAS_OFF_REG_A, 32'h8000);
    pulseCtx(DIV, DDONE);
    checkBit(overflowFlag, 1'b1);
    setCtx(FIRST | SENSE);
    strobe(2'h2, 4'h0);
    checkBit(overflowFlag, 1'b0);
    setCtx(SB5 | SB6);
    strobe(2'h1, 4'h0);
    checkBit(longShift, 1'b1);
    pulseCtx(18'h0, LDONE);
    checkBit(longShift, 1'b0);
    setCtx(MUL);
    strobe(2'h1, 4'h2);
    checkBit(longShift, 1'b1);
    pulseCtx(18'h0, LDONE);
    setCtx(18'h0);
    apb(1'b1, `OCAS_OFF_REG_X, 32'h8001);
    ctl(4'h1, 4'h0, `OCAS_SHIFT_LEFT);
    expResult(16'h0003);
    apb(1'b1, `OCAS_OFF_REG_X, 32'h8002);
    ctl(4'h1, 4'h0, `OCAS_SHIFT_RIGHT);
    expResult(16'hc001);
    setCtx(SB5 | SB6);
    apb(1'b1, `OCAS_OFF_REG_Q, 32'hc000);
    ctl(4'h0, 4'h1, `OCAS_SHIFT_LEFT);
    expResult(16'h8001);
    strobe(2'h0, 4'h0);
    checkBit(bitBucket, 1'b1);
    strobe(2'h1, 4'h0);
    apb(1'b1, `OCAS_OFF_REG_A, 32'h0002);
    ctl(4'h4, 4'h0, `OCAS_SHIFT_LEFT);
    expResult(16'h0005);
    pulseCtx(DIV | DSTEP, LDONE);
    apb(1'b1, `OCAS_OFF_REG_X, 32'h0001);
    apb(1'b1, `OCAS_OFF_REG_Q, 32'h0001);
    ctl(4'h1, 4'h1, `OCAS_SHIFT_NONE);
    apb(1'b0, `OCAS_OFF_STATUS, 32'h0);
    checkBit(rd[3], 1'b1);
    strobe(2'h0, 4'h1);
    checkBit(bitBucket, 1'b0);
    setCtx(SB5 | SB6);
    apb(1'b1, `OCAS_OFF_REG_Q, 32'h0003);
    ctl(4'h0, 4'h1, `OCAS_SHIFT_RIGHT);
    strobe(2'h0, 4'h0);
    checkBit(bitBucket, 1'b1);
    strobe(2'h1, 4'h0);
    ctl(4'h4, 4'h0, `OCAS_SHIFT_RIGHT);
    expResult(16'h8001);
    reportAndStop;
  end
endmodule
bind ocas_adder_shifter ocas_adder_shifter_props i_ocas_adder_shifter_props (.*);

// >>> ocas_adder_shifter_props.sv
// Purpose: Assertions on the overflow, bucket and long-shift flip-flops.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound to the design top from the bench file.
`timescale 1ns/1ps
module ocas_adder_shifter_props (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  // Sequencer
  input wire strobeA,
  input wire strobeB,
  input wire strobeC,
  input wire firstCycle,
  input wire secondCycle,
  input wire operandPhase,
  input wire addOp,
  input wire regToRegOp,
  input wire instrBit6,
  input wire instrBit7,
  input wire multiplyOp,
  input wire divideOp,
  input wire divideDone,
  input wire returnFromTrap,
  input wire senseOverflow,
  input wire memWord15,
  input wire shiftBit5,
  input wire shiftBit6,
  // State
  input wire overflowFlag,
  input wire bitBucket,
  input wire longShift
);
  wire addEv = strobeC & secondCycle & operandPhase & (addOp | regToRegOp);
  wire divSet = divideOp & divideDone;
  wire rftEv = strobeC & firstCycle & returnFromTrap;
  wire senseEv = strobeC & firstCycle & senseOverflow;
  wire riseCause = addEv | divSet | (rftEv & memWord15);
  wire fallCause = (rftEv & ~memWord15) | senseEv;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_RFT_SET: assert property (rftEv && memWord15 |=> overflowFlag)
    else $error("flag not loaded high on return");
  AST_RFT_CLR: assert property (rftEv && !memWord15 && !divSet && !secondCycle |=> !overflowFlag)
    else $error("flag not loaded low on return");
  AST_SENSE_CLR: assert property (senseEv && !returnFromTrap && !divSet && !secondCycle
    |=> !overflowFlag)
    else $error("sense overflow did not clear flag");
  AST_LOGIC_NOSET: assert property (!overflowFlag && strobeC && regToRegOp && (instrBit6 || instrBit7)
    && !addOp && !divSet && !rftEv |=> !overflowFlag)
    else $error("logic operation set the flag");
  AST_FLAG_RISE: assert property ($rose(overflowFlag) |-> $past(riseCause))
    else $error("flag rose without cause");
  AST_FLAG_FALL: assert property ($fell(overflowFlag) |-> $past(fallCause))
    else $error("flag fell without cause");
  AST_LONG_SET: assert property (strobeB && (shiftBit5 && shiftBit6 || multiplyOp || divideOp)
    |=> longShift)
    else $error("long shift not set");
  AST_LONG_RISE: assert property ($rose(longShift) |-> $past(strobeB))
    else $error("long shift rose off strobe");
  AST_BUCKET_HOLD: assert property (!strobeA |=> $stable(bitBucket))
    else $error("bucket changed off strobe");
endmodule

// >>> ocas_defs.vh
// Purpose: Constants for the ones-complement adder/shifter.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Definitions only.
`ifndef OCAS_DEFS_VH
`define OCAS_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OCAS_OFF_CTRL 8'h00
`define OCAS_OFF_REG_A 8'h04
`define OCAS_OFF_REG_Q 8'h08
`define OCAS_OFF_REG_X 8'h0c
`define OCAS_OFF_REG_Y 8'h10
`define OCAS_OFF_REG_P 8'h14
`define OCAS_OFF_REG_MASK 8'h18
`define OCAS_OFF_RESULT 8'h1c
`define OCAS_OFF_STATUS 8'h20

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define OCAS_CTRL_FSEL_LSB 0
`define OCAS_CTRL_SSEL_LSB 4
`define OCAS_CTRL_FUNC_LSB 8
`define OCAS_CTRL_SHIFT_LSB 10
`define OCAS_CTRL_WIDTH 12
`define OCAS_CTRL_RESET 12'h000

// First operand select bits
`define OCAS_FSEL_X 0
`define OCAS_FSEL_Y 1
`define OCAS_FSEL_A 2
`define OCAS_FSEL_INC 3
// Second operand select bits
`define OCAS_SSEL_Q 0
`define OCAS_SSEL_X 1
`define OCAS_SSEL_P 2
`define OCAS_SSEL_MASK 3

// Function codes
`define OCAS_FUNC_ADD 2'h0
`define OCAS_FUNC_XOR 2'h1
`define OCAS_FUNC_AND 2'h2
// Shift codes
`define OCAS_SHIFT_NONE 2'h0
`define OCAS_SHIFT_LEFT 2'h1
`define OCAS_SHIFT_RIGHT 2'h2

// ----------------------------------------------------------------
// Status fields and reset values
// ----------------------------------------------------------------
`define OCAS_STAT_OVF 0
`define OCAS_STAT_BUCKET 1
`define OCAS_STAT_LONG 2
`define OCAS_STAT_WRAP 3
`define OCAS_STAT_OVFDET 4
`define OCAS_REG_RESET 16'h0000

`endif

// >>> ocas_seq_model.sv
// Purpose: Sequencer model issuing one-cycle phase strobes.
// Assumes: The bench holds cycle qualifiers around each strobe.
// Notes: Lag lets a strobe come promptly or several cycles late.
`timescale 1ns/1ps
module ocas_seq_model (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  // Request
  input wire fire,
  input wire [1:0] kind,
  input wire [3:0] lag,
  // Strobes
  output reg strobeA,
  output reg strobeB,
  output reg strobeC,
  output reg busy
);
  reg [3:0] lag_q;
  reg [1:0] kind_q;
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      {strobeA, strobeB, strobeC, busy} <= 4'h0;
      lag_q <= 4'h0;
      kind_q <= 2'h0;
    end
    else
    begin
      {strobeA, strobeB, strobeC} <= 3'h0;
      if (!busy && fire)
      begin
        busy <= 1'b1;
        lag_q <= lag;
        kind_q <= kind;
      end
      else if (busy && lag_q != 4'h0)
        lag_q <= lag_q - 4'h1;
      else if (busy)
      begin
        // Strobes are single pulses, never levels
        busy <= 1'b0;
        strobeA <= (kind_q == 2'h0);
        strobeB <= (kind_q == 2'h1);
        strobeC <= (kind_q == 2'h2);
      end
    end
  end
endmodule
